// *** pgs_phase.v ***
// switching-phase clocks for the three bucks
// assumes a free-running pclk; outputs are flop-driven
`timescale 1ns/1ps
module pgs_phase (
    input wire pclk,
    input wire presetn,
    input wire ccm,
    output reg clk_b1,
    output reg clk_b2,
    output reg clk_b3
);
    reg [3:0] cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            clk_b1 <= 1'b0;
            clk_b2 <= 1'b0;
            clk_b3 <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
            clk_b1 <= cnt[3];
            clk_b3 <= cnt[3];
            // shifted by a quarter period in ccm
            clk_b2 <= ccm ? (cnt[3] ^ cnt[2]) : cnt[3];
        end
    end
endmodule // pgs_phase

// *** pgs_rail_model.sv ***
// analog side stand-in: soft-start done and zero-current flags per rail
// assumes rail_on comes straight from the supervisor
`timescale 1ns/1ps
module pgs_rail_model #(
    parameter RAMP = 20
) (
    input wire pclk,
    input wire [3:0] rail_on,
    output logic [3:0] ss_done = 4'h0,
    output logic [3:0] zcd = 4'h0
);
    int cnt [4];
    logic [3:0] tick = 4'h0;
    // done drops at once when a rail goes off
    always @(posedge pclk) begin
        tick <= tick + 4'h1;
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= rail_on[i] ? (cnt[i] < RAMP ? cnt[i] + 1 : RAMP) : 0;
            ss_done[i] <= rail_on[i] && cnt[i] == RAMP;
            zcd[i] <= tick[3];
        end
    end
endmodule // pgs_rail_model

// *** pgs_regs.vh ***
// register map, field positions and timing constants of the supervisor
// assumes a 32-bit apb slave clocked by pclk at 50 mhz
// Overview of operation
// - power_good high only when on, good, clear
// - buck1 ov/uv, other rails out-of-window drop
// - thermal, ldo dropout, overcurrent drop power_good
// - vin stop, vcc falling lockout, bus faults
// - release after errors clear, start-up, delay
// - programmable release delay setting
// - buck1 disable also shuts buck3 and ldo
// - vin lockout shuts rails in order
// - vin lockout closes enabled discharge switches
// - vcc lockout shuts all rails together
// - vcc lockout keeps discharge switches open except in the off state
// - disabled channel closes its discharge switch
// - restart only after outputs discharged
// - ldo code 0.6v to 3.75v, 50mv step
// - dcm cuts low side at zero current
// - buck3 in phase, buck2 shifted from buck1 unless the buck1 dcm bit is set
// - mapping bit masks bus faults from power_good
`ifndef PGS_REGS_VH
`define PGS_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PGS_ADDR_CTRL 12'h000
`define PGS_ADDR_LDO 12'h004
`define PGS_ADDR_DELAY 12'h008
`define PGS_ADDR_STATUS 12'h00C
`define PGS_ADDR_MASK 12'h010
`define PGS_ADDR_STATE 12'h014
`define PGS_ADDR_ORDER 12'h018
// ----------------------------------------
// control fields
// ----------------------------------------
`define PGS_CTRL_EN_LSB 0
`define PGS_CTRL_DIS_LSB 4
`define PGS_CTRL_DCM_LSB 8
`define PGS_CTRL_MAP_BIT 12
`define PGS_CTRL_RST 32'h0000000F
`define PGS_CTRL_W 13
// ----------------------------------------
// ldo code: 0.6 v + code * 50 mv, up to 3.75 v
// ----------------------------------------
`define PGS_LDO_MAX 6'h3F
`define PGS_LDO_RST 6'h26
`define PGS_LDO_W 6
// ----------------------------------------
// release delay selection in microseconds
// ----------------------------------------
`define PGS_DLY_W 2
`define PGS_DLY_RST 2'h1
`define PGS_CLK_MHZ 50
`define PGS_DLY0_US 32'd100
`define PGS_DLY1_US 32'd500
`define PGS_DLY2_US 32'd1000
`define PGS_DLY3_US 32'd2000
`define PGS_CNT_W 17
// ----------------------------------------
// shutdown order and step time
// ----------------------------------------
`define PGS_ORDER_RST 8'hE4
`define PGS_STEP_US 32'd10
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define PGS_IRQ_W 4
`define PGS_IRQ_PGFALL 0
`define PGS_IRQ_PGRISE 1
`define PGS_IRQ_VINOFF 2
`define PGS_IRQ_VCCOFF 3
// ----------------------------------------
// fault input bits
// ----------------------------------------
`define PGS_FLT_W 11
`define PGS_F_B1OVUV 0
`define PGS_F_B2WIN 1
`define PGS_F_B3WIN 2
`define PGS_F_LDOWIN 3
`define PGS_F_THERM 4
`define PGS_F_DROP 5
`define PGS_F_OC 6
`define PGS_F_VINSTOP 7
`define PGS_F_VCCUV 8
`define PGS_F_COMM 9
`define PGS_F_CRC 10
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define PGS_ST_OFF 2'h0
`define PGS_ST_ON 2'h1
`define PGS_ST_SEQ 2'h2
`define PGS_ST_ALL 2'h3
`endif

// *** pgs_supervisor.v ***
// power-good supervisor and shutdown sequencer with apb registers
// assumes comparator levels are asynchronous; apb on pclk
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pgs_regs.vh"
module pgs_supervisor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [10:0] fault_in,
    input wire vin_uvlo,
    input wire vcc_uvlo,
    input wire [3:0] ss_done,
    input wire [3:0] zcd,
    output reg [3:0] rail_on,
    output reg [3:0] discharge_on,
    output reg [3:0] ls_cut,
    output reg [5:0] ldo_code,
    output reg power_good,
    output wire clk_b1,
    output wire clk_b2,
    output wire clk_b3,
    output wire irq
);
    localparam [31:0] DLY0_W = `PGS_DLY0_US * `PGS_CLK_MHZ;
    localparam [31:0] DLY1_W = `PGS_DLY1_US * `PGS_CLK_MHZ;
    localparam [31:0] DLY2_W = `PGS_DLY2_US * `PGS_CLK_MHZ;
    localparam [31:0] DLY3_W = `PGS_DLY3_US * `PGS_CLK_MHZ;
    localparam [31:0] STEP_W = `PGS_STEP_US * `PGS_CLK_MHZ;
    localparam [31:0] CTRL_RST_W = `PGS_CTRL_RST;
    // cycle counts cut to the counter width on purpose
    localparam [`PGS_CNT_W-1:0] DLY0 = DLY0_W[`PGS_CNT_W-1:0];
    localparam [`PGS_CNT_W-1:0] DLY1 = DLY1_W[`PGS_CNT_W-1:0];
    localparam [`PGS_CNT_W-1:0] DLY2 = DLY2_W[`PGS_CNT_W-1:0];
    localparam [`PGS_CNT_W-1:0] DLY3 = DLY3_W[`PGS_CNT_W-1:0];
    localparam [`PGS_CNT_W-1:0] STEP = STEP_W[`PGS_CNT_W-1:0];

    reg [`PGS_CTRL_W-1:0] ctrl;
    reg [`PGS_DLY_W-1:0] dly_sel;
    reg [7:0] order;
    reg [`PGS_IRQ_W-1:0] status;
    reg [`PGS_IRQ_W-1:0] mask;
    reg [1:0] state;
    reg [1:0] seq_idx;
    reg [`PGS_CNT_W-1:0] cnt;
    reg [`PGS_CNT_W-1:0] rel_cnt;
    reg pg_hold;
    wire [`PGS_FLT_W-1:0] flt;
    wire [1:0] vlev;
    wire [3:0] ssd;
    wire [3:0] zcd_s;
    wire wr_en;
    wire rd_en;
    wire [3:0] en_req;
    wire [3:0] dis_opt;
    wire [3:0] en_eff;
    wire any_fault;
    wire ready_all;
    wire vin_low;
    wire vcc_low;
    wire pg_drop;
    reg [`PGS_IRQ_W-1:0] ev;
    reg [`PGS_IRQ_W-1:0] next_status;

    // ----------------------------------------
    // delay decode
    // ----------------------------------------
    function [`PGS_CNT_W-1:0] dly_cycles;
        input [`PGS_DLY_W-1:0] sel;
        begin
            case (sel)
                2'h0: dly_cycles = DLY0;
                2'h1: dly_cycles = DLY1;
                2'h2: dly_cycles = DLY2;
                default: dly_cycles = DLY3;
            endcase
        end
    endfunction

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    pgs_sync #(.W(`PGS_FLT_W)) u_sync_flt (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(fault_in),
        .level(flt)
    );
    pgs_sync #(.W(10)) u_sync_misc (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({zcd, ss_done, vcc_uvlo, vin_uvlo}),
        .level({zcd_s, ssd, vlev})
    );
    pgs_phase u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .ccm(ctrl[`PGS_CTRL_DCM_LSB] == 1'b0),
        .clk_b1(clk_b1),
        .clk_b2(clk_b2),
        .clk_b3(clk_b3)
    );
    assign vin_low = vlev[0];
    assign vcc_low = vlev[1];

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST_W[`PGS_CTRL_W-1:0];
            ldo_code <= `PGS_LDO_RST;
            dly_sel <= `PGS_DLY_RST;
            mask <= {`PGS_IRQ_W{1'b0}};
            order <= `PGS_ORDER_RST;
        end else if (wr_en) begin
            case (paddr)
                `PGS_ADDR_CTRL: ctrl <= pwdata[`PGS_CTRL_W-1:0];
                `PGS_ADDR_LDO: ldo_code <= pwdata[5:0];
                `PGS_ADDR_DELAY: dly_sel <= pwdata[1:0];
                `PGS_ADDR_MASK: mask <= pwdata[`PGS_IRQ_W-1:0];
                `PGS_ADDR_ORDER: order <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always @* begin
        prdata = 32'h0;
        if (rd_en) begin
            case (paddr)
                `PGS_ADDR_CTRL: prdata[`PGS_CTRL_W-1:0] = ctrl;
                `PGS_ADDR_LDO: prdata[5:0] = ldo_code;
                `PGS_ADDR_DELAY: prdata[1:0] = dly_sel;
                `PGS_ADDR_STATUS: prdata[3:0] = status;
                `PGS_ADDR_MASK: prdata[3:0] = mask;
                `PGS_ADDR_STATE: prdata[10:0] =
                    {power_good, state, rail_on, discharge_on};
                `PGS_ADDR_ORDER: prdata[7:0] = order;
                default: prdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // channel enables
    // ----------------------------------------
    assign dis_opt = ctrl[`PGS_CTRL_DIS_LSB+3:`PGS_CTRL_DIS_LSB];
    // rails 2 and 3 (buck3, ldo) are fed from buck1
    assign en_req = ctrl[`PGS_CTRL_EN_LSB+3:`PGS_CTRL_EN_LSB];
    assign en_eff = {en_req[3] & en_req[0], en_req[2] & en_req[0],
                     en_req[1], en_req[0]};

    // ----------------------------------------
    // shutdown sequencer
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= `PGS_ST_OFF;
            rail_on <= 4'h0;
            discharge_on <= 4'h0;
            seq_idx <= 2'h0;
            cnt <= {`PGS_CNT_W{1'b0}};
        end else begin
            case (state)
                `PGS_ST_OFF: begin
                    rail_on <= 4'h0;
                    discharge_on <= 4'hF;
                    // restart only once every output is discharged
                    if (!vcc_low && !vin_low && cnt == STEP) begin
                        state <= `PGS_ST_ON;
                    end else if (cnt != STEP) begin
                        cnt <= cnt + 1'b1;
                    end
                end
                `PGS_ST_ON: begin
                    rail_on <= en_eff;
                    discharge_on <= ~en_eff;
                    cnt <= {`PGS_CNT_W{1'b0}};
                    seq_idx <= 2'h0;
                    if (vcc_low) begin
                        state <= `PGS_ST_ALL;
                    end else if (vin_low) begin
                        state <= `PGS_ST_SEQ;
                    end
                end
                `PGS_ST_SEQ: begin
                    if (vcc_low) begin
                        state <= `PGS_ST_ALL;
                    end else if (cnt == STEP) begin
                        cnt <= {`PGS_CNT_W{1'b0}};
                        rail_on[order[seq_idx*2+:2]] <= 1'b0;
                        discharge_on[order[seq_idx*2+:2]] <=
                            dis_opt[order[seq_idx*2+:2]];
                        seq_idx <= seq_idx + 2'h1;
                        if (seq_idx == 2'h3) begin
                            state <= `PGS_ST_OFF;
                        end
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                `PGS_ST_ALL: begin
                    rail_on <= 4'h0;
                    discharge_on <= 4'h0;
                    cnt <= {`PGS_CNT_W{1'b0}};
                    if (!vcc_low) begin
                        state <= `PGS_ST_OFF;
                    end
                end
                default: state <= `PGS_ST_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // light-load low-side cutoff
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ls
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ls_cut[g] <= 1'b0;
                end else begin
                    ls_cut[g] <= ctrl[`PGS_CTRL_DCM_LSB+g] &
                                 zcd_s[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // power good
    // ----------------------------------------
    assign any_fault =
        flt[`PGS_F_B1OVUV] | flt[`PGS_F_B2WIN] |
        flt[`PGS_F_B3WIN] | flt[`PGS_F_LDOWIN] |
        flt[`PGS_F_THERM] | flt[`PGS_F_DROP] | flt[`PGS_F_OC] |
        flt[`PGS_F_VINSTOP] | flt[`PGS_F_VCCUV] |
        (~ctrl[`PGS_CTRL_MAP_BIT] &
         (flt[`PGS_F_COMM] | flt[`PGS_F_CRC]));
    assign ready_all = &(ssd | ~en_eff);
    assign pg_drop = (state != `PGS_ST_ON) | any_fault | ~ready_all;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_good <= 1'b0;
            rel_cnt <= {`PGS_CNT_W{1'b0}};
            pg_hold <= 1'b1;
        end else if (pg_drop) begin
            power_good <= 1'b0;
            rel_cnt <= {`PGS_CNT_W{1'b0}};
            pg_hold <= 1'b1;
        end else if (pg_hold) begin
            if (rel_cnt >= dly_cycles(dly_sel)) begin
                pg_hold <= 1'b0;
                power_good <= 1'b1;
            end else begin
                rel_cnt <= rel_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always @* begin
        ev = 4'h0;
        // fall flagged on the edge that drops power_good
        ev[`PGS_IRQ_PGFALL] = power_good & pg_drop;
        ev[`PGS_IRQ_PGRISE] = pg_hold & ~power_good & ~pg_drop &
            (rel_cnt >= dly_cycles(dly_sel));
        ev[`PGS_IRQ_VINOFF] = (state == `PGS_ST_ON) & vin_low & ~vcc_low;
        ev[`PGS_IRQ_VCCOFF] = (state != `PGS_ST_ALL) & vcc_low;
        next_status = status;
        if (wr_en && paddr == `PGS_ADDR_STATUS) begin
            next_status = status & ~pwdata[`PGS_IRQ_W-1:0];
        end
        next_status = next_status | ev;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 4'h0;
        end else begin
            status <= next_status;
        end
    end
    assign irq = |(status & mask);
endmodule // pgs_supervisor

// *** pgs_supervisor_asserts.sv ***
// port-level assertions for the power-good supervisor
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ps
module pgs_sup_chk (
    input wire pclk,
    input wire presetn,
    input wire [10:0] fault_in,
    input wire vin_uvlo,
    input wire vcc_uvlo,
    input wire [3:0] rail_on,
    input wire [3:0] discharge_on,
    input wire power_good
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // power-good
    // ----------------------------------------
    property p_rst_low;
        $rose(presetn) |-> !power_good && rail_on == 4'h0;
    endproperty
    a_rst_low: assert property (p_rst_low)
        else $error("outputs active right after reset");
    property p_pg_on;
        power_good |-> rail_on != 4'h0;
    endproperty
    a_pg_on: assert property (p_pg_on)
        else $error("power good with all rails off");
    property p_pg_fault;
        (|fault_in[8:0])[*8] |-> !power_good;
    endproperty
    a_pg_fault: assert property (p_pg_fault)
        else $error("power good high during a fault");
    property p_pg_rise;
        $rose(power_good) |-> $past(fault_in[8:0], 8) == 9'h000;
    endproperty
    a_pg_rise: assert property (p_pg_rise)
        else $error("power good rose too soon after a fault");
    // ----------------------------------------
    // shutdown and discharge
    // ----------------------------------------
    property p_vcc_off;
        vcc_uvlo[*8] |-> rail_on == 4'h0 && discharge_on == 4'h0;
    endproperty
    a_vcc_off: assert property (p_vcc_off)
        else $error("supply lockout left rails or discharge on");
    property p_b3_b1;
        (!vin_uvlo)[*8] ##0 (rail_on[2] || rail_on[3]) |-> rail_on[0];
    endproperty
    a_b3_b1: assert property (p_b3_b1)
        else $error("buck3 or ldo on without buck1");
    property p_vin_one;
        vin_uvlo[*8] ##0 !vcc_uvlo |->
            $countones($past(rail_on) & ~rail_on) <= 1;
    endproperty
    a_vin_one: assert property (p_vin_one)
        else $error("two rails dropped together in input lockout");
    property p_dis_off;
        (!vin_uvlo && !vcc_uvlo)[*8] ##0 $fell(rail_on[0]) |->
            ##[0:2] discharge_on[0];
    endproperty
    a_dis_off: assert property (p_dis_off)
        else $error("disabled buck1 not discharged");
    c_pg_rise: cover property ($rose(power_good));
    c_pg_fall: cover property ($fell(power_good));
    c_vin_seq: cover property (vin_uvlo && rail_on == 4'h1);
endmodule // pgs_sup_chk

bind pgs_supervisor pgs_sup_chk u_chk (.pclk(pclk), .presetn(presetn),
    .fault_in(fault_in), .vin_uvlo(vin_uvlo), .vcc_uvlo(vcc_uvlo),
    .rail_on(rail_on), .discharge_on(discharge_on), .power_good(power_good));

// *** pgs_sync.v ***
// three-flop synchroniser with a filtered fourth output flop for a bus of asynchronous levels
// assumes inputs come from analog comparators outside pclk
`timescale 1ns/1ps
module pgs_sync #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] level
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    level[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // change accepted once stage 2 and 3 agree
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // pgs_sync

// *** tb.sv ***
// self-checking bench for the power-good supervisor
// assumes the rail model on the analog side and an apb master here
`timescale 1ns/1ps
`include "pgs_regs.vh"
module tb;
    localparam int DLY = `PGS_DLY0_US * `PGS_CLK_MHZ;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vin_uvlo = 1'b0, vcc_uvlo = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [10:0] fault_in = 11'h000;
    logic [3:0] acc;
    logic [3:0] seq [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
    wire [31:0] prdata;
    wire pready, pslverr, power_good, clk_b1, clk_b2, clk_b3, irq;
    wire [3:0] ss_done, zcd, rail_on, discharge_on, ls_cut;
    wire [5:0] ldo_code;
    int miscompares = 0, compares = 0, cyc = 0, n, d2, d3;
    initial forever #10 pclk = ~pclk;
    pgs_supervisor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .vin_uvlo(vin_uvlo), .vcc_uvlo(vcc_uvlo),
        .ss_done(ss_done), .zcd(zcd), .rail_on(rail_on),
        .discharge_on(discharge_on), .ls_cut(ls_cut), .ldo_code(ldo_code),
        .power_good(power_good), .clk_b1(clk_b1), .clk_b2(clk_b2),
        .clk_b3(clk_b3), .irq(irq));
    pgs_rail_model model (.pclk(pclk), .rail_on(rail_on),
        .ss_done(ss_done), .zcd(zcd));
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk1(pslverr, 1'b0);
    endtask
    task automatic wait_pg(input logic v, input int lim);
        n = 0;
        while (power_good !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk1(power_good, v);
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 95000) begin
            miscompares++;
            end_of_test;
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk1(power_good, 1'b0);
        rdchk(`PGS_ADDR_CTRL, `PGS_CTRL_RST);
        rdchk(`PGS_ADDR_LDO, {26'h0, `PGS_LDO_RST});
        rdchk(`PGS_ADDR_DELAY, {30'h0, `PGS_DLY_RST});
        rdchk(`PGS_ADDR_ORDER, {24'h0, `PGS_ORDER_RST});
        apb(1'b1, 12'h01C, 32'hFFFFFFFF);
        rdchk(12'h01C, 32'h0);
        for (int c = 0; c < 64; c += 63) begin
            apb(1'b1, `PGS_ADDR_LDO, c);
            rdchk(`PGS_ADDR_LDO, c);
            chk({26'h0, ldo_code}, c);
        end
        apb(1'b1, `PGS_ADDR_DELAY, 32'h0);
        apb(1'b1, `PGS_ADDR_MASK, 32'hF);
        apb(1'b1, `PGS_ADDR_ORDER, 32'h1B);
        wait_pg(1'b1, 7000);
        tdone("power up");
        for (int b = 0; b < 11; b++) begin
            fault_in <= 11'h001 << b;
            repeat (8) @(posedge pclk);
            chk1(power_good, 1'b0);
            fault_in <= 11'h000;
            wait_pg(1'b1, 6000);
            chk1(n >= DLY && n <= DLY + 12, 1'b1);
        end
        rdchk(`PGS_ADDR_STATUS, 32'h3);
        chk1(irq, 1'b1);
        apb(1'b1, `PGS_ADDR_MASK, 32'h0);
        @(posedge pclk);
        chk1(irq, 1'b0);
        apb(1'b1, `PGS_ADDR_MASK, 32'hF);
        apb(1'b1, `PGS_ADDR_STATUS, 32'hF);
        rdchk(`PGS_ADDR_STATUS, 32'h0);
        chk1(irq, 1'b0);
        tdone("faults");
        apb(1'b1, `PGS_ADDR_CTRL, 32'h100F);
        fault_in <= 11'h600;
        repeat (8) @(posedge pclk);
        chk1(power_good, 1'b1);
        fault_in <= 11'h000;
        repeat (8) @(posedge pclk);
        chk1(power_good, 1'b1);
        apb(1'b1, `PGS_ADDR_CTRL, 32'hF);
        d2 = 0;
        d3 = 0;
        acc = 4'h0;
        repeat (32) begin
            @(negedge pclk);
            d2 += (clk_b2 !== clk_b1);
            d3 += (clk_b3 !== clk_b1);
            acc |= ls_cut;
        end
        chk(d3, 0);
        chk(d2, 16);
        chk(acc, 4'h0);
        apb(1'b1, `PGS_ADDR_CTRL, 32'hF0F);
        repeat (64) @(negedge pclk) acc |= ls_cut;
        chk1(acc != 4'h0, 1'b1);
        apb(1'b1, `PGS_ADDR_CTRL, 32'hE);
        repeat (8) @(posedge pclk);
        chk(rail_on, 4'h2);
        chk(discharge_on, 4'hD);
        apb(1'b1, `PGS_ADDR_CTRL, 32'hF);
        wait_pg(1'b1, 6000);
        tdone("modes");
        apb(1'b1, `PGS_ADDR_CTRL, 32'hFF);
        vin_uvlo <= 1'b1;
        foreach (seq[i]) begin
            n = 0;
            while (rail_on !== seq[i] && n < 600) begin
                @(posedge pclk);
                n++;
            end
            repeat (2) @(posedge pclk);
            chk(rail_on, seq[i]);
            chk(discharge_on, {28'h0, ~seq[i]});
        end
        chk1(power_good, 1'b0);
        chk1(irq, 1'b1);
        vin_uvlo <= 1'b0;
        wait_pg(1'b1, 7000);
        tdone("input lockout");
        vcc_uvlo <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(rail_on, 4'h0);
        chk(discharge_on, 4'h0);
        chk1(power_good, 1'b0);
        rdchk(`PGS_ADDR_STATE, 32'h300);
        vcc_uvlo <= 1'b0;
        tdone("supply lockout");
        end_of_test;
    end
endmodule // tb
